// >>> verilog/timer_pkg.sv
// shared constants and carriers for the 16-bit waveform timer
package timer_pkg;
  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] count_t;

  // apb request and answer carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apbReq_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apbResp_t;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_COUNT     = 8'h04;
  localparam logic [7:0] OFS_COMPARE_A = 8'h08;
  localparam logic [7:0] OFS_COMPARE_B = 8'h0C;
  localparam logic [7:0] OFS_CAPTURE   = 8'h10;
  localparam logic [7:0] OFS_FLAGS     = 8'h14;
  localparam logic [7:0] OFS_PIN_DIR   = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;

  // control and status field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ACTA_LSB  = 4;
  localparam int CTRL_ACTB_LSB  = 6;
  localparam int CTRL_PRESC_LSB = 8;
  localparam int STAT_CMPA_LSB  = 16;

  // flag bit positions
  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAPT = 3;

  // waveform mode codes
  localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
  localparam logic [3:0] MODE_FAST_8    = 4'h5;
  localparam logic [3:0] MODE_FAST_9    = 4'h6;
  localparam logic [3:0] MODE_FAST_10   = 4'h7;
  localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
  localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

  // count landmarks
  localparam count_t TOP_8        = 16'h00FF;
  localparam count_t TOP_9        = 16'h01FF;
  localparam count_t TOP_10       = 16'h03FF;
  localparam count_t COUNT_MAX    = 16'hFFFF;
  localparam count_t COUNT_BOTTOM = 16'h0000;

  // channel output actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // prescale selections and their division factors
  localparam logic [2:0] PRESC_STOP = 3'h0;
  localparam logic [2:0] PRESC_1    = 3'h1;
  localparam logic [2:0] PRESC_8    = 3'h2;
  localparam logic [2:0] PRESC_64   = 3'h3;
  localparam logic [2:0] PRESC_256  = 3'h4;
  localparam logic [2:0] PRESC_1024 = 3'h5;
  localparam int DIV_1    = 1;
  localparam int DIV_8    = 8;
  localparam int DIV_64   = 64;
  localparam int DIV_256  = 256;
  localparam int DIV_1024 = 1024;
endpackage

// >>> verilog/timer_prescaler.sv
// timer clock enable generator dividing the i/o clock
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler #(
  parameter int DIV_W = 10
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] prescSel,
  output logic            tick
);
  import timer_pkg::*;

  logic [DIV_W-1:0] divCount;

  // mask of low bits that must be zero for a tick
  function automatic logic [DIV_W-1:0] divMask(input logic [2:0] sel);
    case (sel)
      PRESC_8:    divMask = DIV_W'(DIV_8 - 1);
      PRESC_64:   divMask = DIV_W'(DIV_64 - 1);
      PRESC_256:  divMask = DIV_W'(DIV_256 - 1);
      PRESC_1024: divMask = DIV_W'(DIV_1024 - 1);
      default:    divMask = DIV_W'(DIV_1 - 1);
    endcase
  endfunction

  // free running divider
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCount <= '0;
    end else begin
      divCount <= DIV_W'(divCount + 1'b1);
    end
  end

  // one tick per 1, 8, 64, 256 or 1024 clocks; stopped or reserved gives none
  assign tick = (prescSel != PRESC_STOP) && (prescSel <= PRESC_1024) &&
                ((divCount & divMask(prescSel)) == '0);
endmodule
`default_nettype wire

// >>> verilog/timer_wave_out.sv
// one channel output register with its compare action logic
`timescale 1ns/100ps
`default_nettype none
module timer_wave_out (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       match,
  input  wire logic       atTop,
  input  wire logic       fastPwm,
  input  wire logic       toggleOk,
  input  wire logic [1:0] action,
  output logic            waveReg
);
  import timer_pkg::*;

  // output register update on timer ticks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waveReg <= 1'b0;
    end else if (tick) begin
      if (fastPwm) begin
        unique case (action)
          ACT_NONE:   waveReg <= waveReg;
          ACT_TOGGLE: waveReg <= waveReg ^ (match & toggleOk);
          ACT_NONINV: begin
            if (atTop) begin
              waveReg <= 1'b1;
            end else if (match) begin
              waveReg <= 1'b0;
            end
          end
          ACT_INV: begin
            if (atTop) begin
              waveReg <= 1'b0;
            end else if (match) begin
              waveReg <= 1'b1;
            end
          end
        endcase
      end else if (match) begin
        unique case (action)
          ACT_NONE:   waveReg <= waveReg;
          ACT_TOGGLE: waveReg <= ~waveReg;
          ACT_NONINV: waveReg <= 1'b0;
          ACT_INV:    waveReg <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/timer16_waveform.sv
// 16-bit timer with clear-on-match and fast pwm waveform generation
//
// Overview of operation
// - clear-on-match top is unbuffered; top below count means wrap via 0xFFFF
// - clear-on-match, action 1 toggles channel A output on every match
// - channel pin shows waveform only when its direction bit is 1
// - toggle frequency is io clock over 2*N*(1+compare A)
// - prescale factor is 1, 8, 64, 256 or 1024 io clocks per count
// - clear-on-match sets overflow flag when count passes max to zero
// - modes 5, 6, 7, 14, 15 are fast pwm, counting zero to top
// - non-inverting clears on match, sets at bottom; inverting the opposite
// - fast pwm top is 0xFF, 0x1FF, 0x3FF, capture or compare A
// - fast pwm sets overflow at top, plus top register's own flag
// - channel flag sets when count equals its active compare value
// - fixed top modes zero compare bits above the top width on write
// - capture top is unbuffered; lowering below count wraps via 0xFFFF
// - fast pwm compare writes go to buffer, loaded at top
// - fast pwm action 2 is non-inverting, action 3 inverting
// - fast pwm period is N times one plus top io clocks
// - compare zero gives a one-count spike; compare top a steady level
// - mode 15 action 1 toggles channel A on each match
// - clear-on-match clears counter at compare A (4) or capture (12)
// - action zero leaves the output register untouched
// - reset clears each channel output register
// - a counter write blocks compare matches in the next timer tick
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform #(
  parameter int CHANNELS = 2,
  parameter int DIV_W    = 10
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire timer_pkg::apbReq_t apbReq,
  output timer_pkg::apbResp_t    apbResp,
  output logic [CHANNELS-1:0]    chanWaveOut,
  output logic [CHANNELS-1:0]    chanOutEn_n
);
  import timer_pkg::*;

  logic [3:0]          waveModeSel;
  logic [1:0]          chanAction [CHANNELS];
  logic [2:0]          prescSel;
  count_t              timerCount;
  count_t              compareBuf [CHANNELS];
  count_t              compareAct [CHANNELS];
  count_t              captureTop;
  logic [3:0]          flags;
  logic [CHANNELS-1:0] pinDir;
  logic                blockPending;
  logic [31:0]         readData;
  logic                tick;
  logic                isCtc;
  logic                isFast;
  count_t              topValue;
  logic                atTop;
  logic                countWr;
  logic [CHANNELS-1:0] match;
  logic [CHANNELS-1:0] cmpWr;
  logic [3:0]          flagSet;
  logic [3:0]          flagClr;
  logic                apbSetup;
  logic                apbWrite;
  count_t              next_count;
  logic [CHANNELS-1:0] waveReg;

  // address decode shared by write strobes and the error answer
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      OFS_CONTROL, OFS_COUNT, OFS_COMPARE_A, OFS_COMPARE_B,
      OFS_CAPTURE, OFS_FLAGS, OFS_PIN_DIR, OFS_STATUS: isMapped = 1'b1;
      default:                                         isMapped = 1'b0;
    endcase
  endfunction

  // top value selected by the waveform mode
  function automatic count_t topOf(input logic [3:0] mode,
                                   input count_t cmpA,
                                   input count_t capt);
    case (mode)
      MODE_FAST_8:                   topOf = TOP_8;
      MODE_FAST_9:                   topOf = TOP_9;
      MODE_FAST_10:                  topOf = TOP_10;
      MODE_CTC_CAPT, MODE_FAST_CAPT: topOf = capt;
      MODE_CTC_CMPA, MODE_FAST_CMPA: topOf = cmpA;
      default:                       topOf = COUNT_MAX;
    endcase
  endfunction

  // writable bits of a compare value in fixed top modes
  function automatic count_t widthMask(input logic [3:0] mode);
    case (mode)
      MODE_FAST_8:  widthMask = TOP_8;
      MODE_FAST_9:  widthMask = TOP_9;
      MODE_FAST_10: widthMask = TOP_10;
      default:      widthMask = COUNT_MAX;
    endcase
  endfunction

  // timer clock enable
  timer_prescaler #(
    .DIV_W(DIV_W)
  ) prescaler (
    .clk     (clk),
    .reset   (reset),
    .prescSel(prescSel),
    .tick    (tick)
  );

  // mode decode and top selection
  assign isCtc    = (waveModeSel == MODE_CTC_CMPA) ||
                    (waveModeSel == MODE_CTC_CAPT);
  assign isFast   = (waveModeSel == MODE_FAST_8) ||
                    (waveModeSel == MODE_FAST_9) ||
                    (waveModeSel == MODE_FAST_10) ||
                    (waveModeSel == MODE_FAST_CAPT) ||
                    (waveModeSel == MODE_FAST_CMPA);
  assign topValue = topOf(waveModeSel, compareAct[0], captureTop);
  assign atTop    = tick && (isCtc || isFast) &&
                    (timerCount == topValue);

  // apb strobes; every transfer is answered without wait states
  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite &&
                    isMapped(apbReq.paddr);
  assign countWr  = apbWrite && (apbReq.paddr == OFS_COUNT);
  assign cmpWr[0] = apbWrite && (apbReq.paddr == OFS_COMPARE_A);
  assign cmpWr[1] = apbWrite && (apbReq.paddr == OFS_COMPARE_B);
  assign apbResp = '{prdata:  readData,
                     pready:  1'b1,
                     pslverr: apbReq.psel && apbReq.penable &&
                              !isMapped(apbReq.paddr)};

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readData <= '0;
    end else if (apbSetup && !apbReq.pwrite) begin
      case (apbReq.paddr)
        OFS_CONTROL:   readData <= {20'h00000, 1'b0, prescSel, chanAction[1],
                                    chanAction[0], waveModeSel};
        OFS_COUNT:     readData <= {16'h0000, timerCount};
        OFS_COMPARE_A: readData <= {16'h0000, compareBuf[0]};
        OFS_COMPARE_B: readData <= {16'h0000, compareBuf[1]};
        OFS_CAPTURE:   readData <= {16'h0000, captureTop};
        OFS_FLAGS:     readData <= {28'h0000000, flags};
        OFS_PIN_DIR:   readData <= {30'h00000000, pinDir};
        OFS_STATUS:    readData <= {compareAct[0], 13'h0000, blockPending,
                                    waveReg};
        default:       readData <= '0;
      endcase
    end
  end

  // control register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waveModeSel   <= 4'h0;
      chanAction[0] <= ACT_NONE;
      chanAction[1] <= ACT_NONE;
      prescSel      <= PRESC_STOP;
    end else if (apbWrite && apbReq.paddr == OFS_CONTROL) begin
      waveModeSel   <= apbReq.pwdata[CTRL_MODE_LSB +: 4];
      chanAction[0] <= apbReq.pwdata[CTRL_ACTA_LSB +: 2];
      chanAction[1] <= apbReq.pwdata[CTRL_ACTB_LSB +: 2];
      prescSel      <= apbReq.pwdata[CTRL_PRESC_LSB +: 3];
    end
  end

  // capture top and pin direction registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      captureTop <= COUNT_BOTTOM;
      pinDir     <= '0;
    end else begin
      if (apbWrite && apbReq.paddr == OFS_CAPTURE) begin
        captureTop <= apbReq.pwdata[CNT_W-1:0];
      end
      if (apbWrite && apbReq.paddr == OFS_PIN_DIR) begin
        pinDir <= apbReq.pwdata[CHANNELS-1:0];
      end
    end
  end

  // next count: clear after top, else count up and wrap past max
  always_comb begin
    if (atTop) begin
      next_count = COUNT_BOTTOM;
    end else begin
      next_count = count_t'(timerCount + 16'h0001);
    end
  end

  // counter; a software write wins over counting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timerCount <= COUNT_BOTTOM;
    end else if (countWr) begin
      timerCount <= apbReq.pwdata[CNT_W-1:0];
    end else if (tick) begin
      timerCount <= next_count;
    end
  end

  // match blocking after a counter write, held until the next tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blockPending <= 1'b0;
    end else if (countWr) begin
      blockPending <= 1'b1;
    end else if (tick) begin
      blockPending <= 1'b0;
    end
  end

  // compare buffers and active values per channel
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign match[ch] = tick && !blockPending &&
                         (timerCount == compareAct[ch]);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          compareBuf[ch] <= COUNT_BOTTOM;
          compareAct[ch] <= COUNT_BOTTOM;
        end else begin
          if (cmpWr[ch]) begin
            compareBuf[ch] <= apbReq.pwdata[CNT_W-1:0] &
                              widthMask(waveModeSel);
          end
          if (!isFast && cmpWr[ch]) begin
            compareAct[ch] <= apbReq.pwdata[CNT_W-1:0];
          end else if (isFast && atTop) begin
            compareAct[ch] <= compareBuf[ch];
          end
        end
      end

      timer_wave_out wave (
        .clk     (clk),
        .reset   (reset),
        .tick    (tick),
        .match   (match[ch]),
        .atTop   (atTop),
        .fastPwm (isFast),
        .toggleOk(ch == 0 ? (waveModeSel == MODE_FAST_CMPA) : 1'b0),
        .action  (chanAction[ch]),
        .waveReg (waveReg[ch])
      );

      // pin driven only while its direction bit selects output
      assign chanOutEn_n[ch] = ~pinDir[ch];
    end
  endgenerate

  assign chanWaveOut = waveReg;

  // flag set and write-one-to-clear terms
  always_comb begin
    flagSet            = '0;
    flagSet[FLAG_OVF]  = isFast ? atTop
                                : (tick && timerCount == COUNT_MAX);
    flagSet[FLAG_CMPA] = match[0] ||
                         (atTop && waveModeSel == MODE_FAST_CMPA);
    flagSet[FLAG_CMPB] = match[1];
    flagSet[FLAG_CAPT] = atTop && waveModeSel == MODE_FAST_CAPT;
    flagClr            = '0;
    if (apbWrite && apbReq.paddr == OFS_FLAGS) begin
      flagClr = apbReq.pwdata[3:0];
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flagClr) | flagSet;
    end
  end

  // counter reaching top in clear-on-match mode
  sequence s_ctcTop;
    tick && isCtc && !countWr && timerCount == topValue;
  endsequence

  // counter write followed by a tick in the very next cycle
  sequence s_writeThenTick;
    countWr ##1 (!countWr && tick);
  endsequence

  property p_ctcClear;
    @(posedge clk) disable iff (reset)
    s_ctcTop |=> timerCount == COUNT_BOTTOM;
  endproperty
  a_ctcClear: assert property (p_ctcClear)
    else $error("counter not cleared after top in clear-on-match mode");

  property p_missedTop;
    @(posedge clk) disable iff (reset)
    tick && (isCtc || isFast) && !countWr && timerCount == COUNT_MAX &&
    topValue != COUNT_MAX |=> timerCount == COUNT_BOTTOM;
  endproperty
  a_missedTop: assert property (p_missedTop)
    else $error("counter did not wrap past max after missed top");

  property p_ctcOverflow;
    @(posedge clk) disable iff (reset)
    tick && isCtc && timerCount == COUNT_MAX |=> flags[FLAG_OVF];
  endproperty
  a_ctcOverflow: assert property (p_ctcOverflow)
    else $error("overflow flag missing at max to zero");

  property p_fastTopFlags;
    @(posedge clk) disable iff (reset)
    atTop && isFast |=> flags[FLAG_OVF] &&
      ($past(waveModeSel) != MODE_FAST_CMPA || flags[FLAG_CMPA]) &&
      ($past(waveModeSel) != MODE_FAST_CAPT || flags[FLAG_CAPT]);
  endproperty
  a_fastTopFlags: assert property (p_fastTopFlags)
    else $error("top flags missing in fast pwm");

  property p_bufferLoad;
    @(posedge clk) disable iff (reset)
    atTop && isFast |=> compareAct[0] == $past(compareBuf[0]);
  endproperty
  a_bufferLoad: assert property (p_bufferLoad)
    else $error("active compare A not loaded from buffer at top");

  property p_matchBlock;
    @(posedge clk) disable iff (reset)
    s_writeThenTick |-> match == '0 && !flagSet[FLAG_CMPB];
  endproperty
  a_matchBlock: assert property (p_matchBlock)
    else $error("compare match not blocked after counter write");

  property p_ctcToggle;
    @(posedge clk) disable iff (reset)
    !isFast && chanAction[0] == ACT_TOGGLE && match[0]
      |=> waveReg[0] != $past(waveReg[0]);
  endproperty
  a_ctcToggle: assert property (p_ctcToggle)
    else $error("channel A did not toggle on match");

  property p_fastBottom;
    @(posedge clk) disable iff (reset)
    atTop && isFast && chanAction[0] == ACT_NONINV |=> waveReg[0];
  endproperty
  a_fastBottom: assert property (p_fastBottom)
    else $error("non-inverting output not set at bottom");

  property p_fixedMask;
    @(posedge clk) disable iff (reset)
    cmpWr[0] && waveModeSel == MODE_FAST_8 |=> compareBuf[0][15:8] == 8'h00;
  endproperty
  a_fixedMask: assert property (p_fixedMask)
    else $error("compare bits above fixed top width not zeroed");
endmodule
`default_nettype wire

// >>> testbench/pin_load_model.sv
// loads on the channel pins, resolving each pin level
`timescale 1ns/100ps
`default_nettype none
module pin_load_model #(
  parameter int CHANNELS = 2
) (
  input  wire logic [CHANNELS-1:0] wave,
  input  wire logic [CHANNELS-1:0] outEn_n,
  output logic      [CHANNELS-1:0] pinLevel
);
  logic [CHANNELS-1:0] lastDriven = '0;

  // remember what each pin last showed while it was driven
  always @(wave or outEn_n) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (!outEn_n[i]) lastDriven[i] = wave[i];
    end
  end

  // no pull on these pins: a released pin drifts away from its old level
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      pinLevel[i] = outEn_n[i] ? ~lastDriven[i] : wave[i];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/timer16_waveform_bench.sv
// self-checking bench for the 16-bit waveform timer
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform_bench;
  import timer_pkg::*;
  logic        clk     = 1'b0;
  logic        reset   = 1'b1;
  apbReq_t     apbReq  = '0;
  apbResp_t    apbResp;
  logic [1:0]  chanWaveOut;
  logic [1:0]  chanOutEn_n;
  logic [1:0]  pinLevel;
  logic [31:0] rd;
  logic        err;
  logic        lw;
  int          badCount = 0;
  int          nChecks  = 0;
  int          n;
  logic [2:0]  pscs [5] = '{PRESC_1, PRESC_8, PRESC_64, PRESC_256,
                            PRESC_1024};
  int          divs [5] = '{DIV_1, DIV_8, DIV_64, DIV_256, DIV_1024};
  logic [3:0]  modes[3] = '{MODE_FAST_8, MODE_FAST_9, MODE_FAST_10};
  count_t      tops [3] = '{TOP_8, TOP_9, TOP_10};

  // free-running i/o clock
  always #2 clk = ~clk;

  timer16_waveform #(.CHANNELS(2), .DIV_W(10)) timer16_waveform_i (
    .clk(clk), .reset(reset), .apbReq(apbReq), .apbResp(apbResp),
    .chanWaveOut(chanWaveOut), .chanOutEn_n(chanOutEn_n));
  pin_load_model #(.CHANNELS(2)) pin_load_model_i (
    .wave(chanWaveOut), .outEn_n(chanOutEn_n), .pinLevel(pinLevel));

  task test_done;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (apbResp.pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      badCount++;
      $display("FAIL apb timeout");
      test_done;
    end
    rd = apbResp.prdata;
    err = apbResp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, e, rd);
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] m,
    input logic [1:0] a, input logic [1:0] b, input logic [2:0] p);
    return {21'h000000, p, b, a, m};
  endfunction

  // length in cycles of the next whole stretch at level lvl
  task lvl_len(input int ch, input logic lvl, output int len);
    int k;
    k = 0;
    len = 0;
    while (chanWaveOut[ch] !== ~lvl && k < 5000) begin
      @(posedge clk);
      k++;
    end
    while (chanWaveOut[ch] !== lvl && k < 5000) begin
      @(posedge clk);
      k++;
    end
    while (chanWaveOut[ch] === lvl && k < 5000) begin
      @(posedge clk);
      k++;
      len++;
    end
    if (k >= 5000) begin
      badCount++;
      $display("FAIL wave timeout");
      test_done;
    end
  endtask

  task t_reset;
    chk("wave", 32'h0, chanWaveOut);
    chk("oe_n", 32'h3, chanOutEn_n);
    rdchk("control", OFS_CONTROL, 32'h0);
    rdchk("count", OFS_COUNT, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task t_ctc;
    wr(OFS_PIN_DIR, 32'h1);
    wr(OFS_COMPARE_A, 32'h2);
    wr(OFS_FLAGS, 32'hF);
    wr(OFS_CONTROL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, ACT_NONE, PRESC_1));
    lvl_len(0, 1'b1, n);
    chk("ctc half period", 32'd3, n);
    chk("oe_n", 32'h2, chanOutEn_n);
    chk("pin", chanWaveOut[0], pinLevel[0]);
    rdchk("ctc flags", OFS_FLAGS, 32'h6);
    chk("chan b idle", 32'h0, chanWaveOut[1]);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CONTROL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, ACT_NONE, PRESC_STOP));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_COMPARE_A, 32'h0);
      wr(OFS_CONTROL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, ACT_NONE, pscs[i]));
      lvl_len(0, 1'b0, n);
      chk("prescaled half", divs[i], n);
    end
    $display("test ctc done");
  endtask

  task t_wrap;
    int k;
    wr(OFS_CONTROL, ctl(MODE_CTC_CMPA, ACT_NONE, ACT_NONE, PRESC_STOP));
    wr(OFS_COMPARE_A, 32'hFFF8);
    wr(OFS_COUNT, 32'hFFE0);
    wr(OFS_FLAGS, 32'hF);
    wr(OFS_CONTROL, ctl(MODE_CTC_CMPA, ACT_NONE, ACT_NONE, PRESC_1));
    wr(OFS_COMPARE_A, 32'h4);
    rdchk("no match yet", OFS_FLAGS, 32'h0);
    k = 0;
    rd = 32'h0;
    while (rd[FLAG_CMPA] !== 1'b1 && k < 40) begin
      apb(1'b0, OFS_FLAGS, 32'h0);
      k++;
    end
    chk("wrap flags", 32'h7, rd);
    $display("test wrap done");
  endtask

  task t_fast;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONTROL, ctl(modes[i], ACT_NONINV, ACT_INV, PRESC_STOP));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_COMPARE_A, 32'hF010);
      wr(OFS_COMPARE_B, 32'hF010);
      rdchk("masked compare", OFS_COMPARE_A, 32'h10);
      wr(OFS_FLAGS, 32'hF);
      wr(OFS_CONTROL, ctl(modes[i], ACT_NONINV, ACT_INV, PRESC_1));
      lvl_len(0, 1'b1, n);
      chk("noninv high", 32'h11, n);
      lvl_len(0, 1'b0, n);
      chk("noninv low", 32'(tops[i]) - 32'h10, n);
      lvl_len(1, 1'b1, n);
      chk("inv high", 32'(tops[i]) - 32'h10, n);
      rdchk("fast flags", OFS_FLAGS, 32'h7);
    end
    $display("test fast pwm done");
  endtask

  task t_capt;
    int k;
    wr(OFS_CONTROL, ctl(MODE_FAST_CAPT, ACT_NONINV, ACT_NONINV, PRESC_STOP));
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CAPTURE, 32'h10);
    wr(OFS_COMPARE_A, 32'h0);
    wr(OFS_COMPARE_B, 32'h10);
    wr(OFS_FLAGS, 32'hF);
    wr(OFS_CONTROL, ctl(MODE_FAST_CAPT, ACT_NONINV, ACT_NONINV, PRESC_1));
    lvl_len(0, 1'b1, n);
    chk("spike", 32'h1, n);
    lvl_len(0, 1'b0, n);
    chk("spike gap", 32'h10, n);
    k = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (chanWaveOut[1] === 1'b1) k++;
    end
    chk("steady b", 32'd40, k);
    rdchk("capt flags", OFS_FLAGS, 32'hF);
    // counter write while stopped: first tick at top blocks the B match
    wr(OFS_CONTROL, ctl(MODE_FAST_CAPT, ACT_NONINV, ACT_NONINV, PRESC_STOP));
    wr(OFS_COUNT, 32'h10);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("block pending", 32'h1, rd[2]);
    wr(OFS_FLAGS, 32'hF);
    wr(OFS_CONTROL, ctl(MODE_FAST_CAPT, ACT_NONINV, ACT_NONINV, PRESC_1));
    rdchk("blocked flags", OFS_FLAGS, 32'h9);
    wr(OFS_COUNT, 32'h0);
    $display("test capture top done");
  endtask

  task t_toggle;
    wr(OFS_CONTROL, ctl(MODE_FAST_CMPA, ACT_TOGGLE, ACT_NONE, PRESC_STOP));
    wr(OFS_COUNT, 32'h0);
    wr(OFS_COMPARE_A, 32'h10);
    wr(OFS_CONTROL, ctl(MODE_FAST_CMPA, ACT_TOGGLE, ACT_NONE, PRESC_1));
    lvl_len(0, 1'b1, n);
    chk("toggle half", 32'h11, n);
    lw = chanWaveOut[0];
    wr(OFS_COMPARE_A, 32'h20);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("active held", 32'h10, rd[31:16]);
    rdchk("buffer", OFS_COMPARE_A, 32'h20);
    lvl_len(0, ~lw, n);
    chk("reloaded half", 32'h21, n);
    $display("test toggle done");
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_ctc;
    t_wrap;
    t_fast;
    t_capt;
    t_toggle;
    test_done;
  end
endmodule
`default_nettype wire
